// [rtl/pcsc_defs.svh]
// Register indices, reset values and bus constants for the pc/stack/context block.
// Assumes a 32-bit APB bus where byte address = register index times four.
`ifndef PCSC_DEFS_SVH
`define PCSC_DEFS_SVH

// Register indices (byte address is index shifted left by two)
`define PCSC_IDX_PC_LOW 12'hfe0
`define PCSC_IDX_PC_LATCH 12'hfe1
`define PCSC_IDX_FLAGS_CTX 12'hfe4
`define PCSC_IDX_WORK_CTX 12'hfe5
`define PCSC_IDX_BANK_CTX 12'hfe6
`define PCSC_IDX_LATCH_CTX 12'hfe7
`define PCSC_IDX_P0L_CTX 12'hfe8
`define PCSC_IDX_P0H_CTX 12'hfe9
`define PCSC_IDX_P1L_CTX 12'hfea
`define PCSC_IDX_P1H_CTX 12'hfeb
`define PCSC_IDX_STK_PTR 12'hfed
`define PCSC_IDX_TOS_LOW 12'hfee
`define PCSC_IDX_TOS_HIGH 12'hfef

// Reset values
`define PCSC_PC_RESET 15'h0000
`define PCSC_SP_RESET 5'h1f
`define PCSC_LATCH_RESET 7'h00

// Bus address layout
`define PCSC_ADDR_W 16
`define PCSC_IDX_LSB 2
`define PCSC_IDX_MSB 13

`endif

// [rtl/pcsc_pkg.sv]
// Types shared by the pc/stack/context block.
// Assumes pcsc_defs.svh supplies all numeric constants.
package pcsc_pkg;

  // One full set of interrupt context values
  typedef struct packed {
    logic [2:0] flags;   // Zero, digit carry, carry
    logic [7:0] work;    // Working register
    logic [4:0] bank;    // Bank select register
    logic [6:0] pc_high_latch;  // Program counter high-part latch
    logic [7:0] p0l;     // Pointer 0 low byte
    logic [7:0] p0h;     // Pointer 0 high byte
    logic [7:0] p1l;     // Pointer 1 low byte
    logic [7:0] p1h;     // Pointer 1 high byte
  } pcsc_ctx_s;

  // Decoded register index with a hit flag
  typedef struct packed {
    logic hit;
    logic [11:0] idx;
  } pcsc_sel_s;

endpackage : pcsc_pkg

// [rtl/pcsc_regs.sv]
// Program counter, return-stack window and interrupt context copies.
// Assumes an APB master on clk, and core strobes synchronous to clk.
`timescale 1ns/1ps
`include "pcsc_defs.svh"

module pcsc_regs #(
  parameter int STK_DEPTH = 16,  // Return stack entries
  parameter int SP_W = 5         // Stack pointer width, one spare bit
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // Core-side reset other than power-on or brown-out
  input wire logic core_reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PCSC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core strobes and live context
  input wire logic pc_step,
  input wire logic irq_entry,
  input wire logic irq_return,
  input wire pcsc_pkg::pcsc_ctx_s live_ctx,
  // Results towards the core
  output logic [14:0] pc,
  output pcsc_pkg::pcsc_ctx_s restore_ctx,
  output logic restore_valid
);
  import pcsc_pkg::*;

  // Refuse sizes that the pointer arithmetic cannot serve
  if (SP_W != $clog2(STK_DEPTH) + 1) begin : g_bad_sp
    $error("pcsc_regs: SP_W must be log2(STK_DEPTH) plus one");
  end
  if (STK_DEPTH < 2) begin : g_bad_depth
    $error("pcsc_regs: STK_DEPTH too small");
  end

  // Decode an APB address into a word index; misaligned or high is a miss
  function automatic pcsc_sel_s decode(input logic [`PCSC_ADDR_W-1:0] a);
    pcsc_sel_s s;
    s.idx = a[`PCSC_IDX_MSB:`PCSC_IDX_LSB];
    s.hit = (a[`PCSC_ADDR_W-1:`PCSC_IDX_MSB+1] == '0) && (a[`PCSC_IDX_LSB-1:0] == '0);
    return s;
  endfunction

  // Whether an index names a register of this block
  function automatic logic mapped(input logic [11:0] idx);
    logic m;
    m = 1'b0;
    case (idx)
      `PCSC_IDX_PC_LOW, `PCSC_IDX_PC_LATCH, `PCSC_IDX_FLAGS_CTX,
      `PCSC_IDX_WORK_CTX, `PCSC_IDX_BANK_CTX, `PCSC_IDX_LATCH_CTX,
      `PCSC_IDX_P0L_CTX, `PCSC_IDX_P0H_CTX, `PCSC_IDX_P1L_CTX,
      `PCSC_IDX_P1H_CTX, `PCSC_IDX_STK_PTR, `PCSC_IDX_TOS_LOW,
      `PCSC_IDX_TOS_HIGH: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // Register state
  logic [14:0] pc_q;             // Program counter
  logic [6:0] pc_high_latch_q;   // High-part latch, software writable
  logic [SP_W-1:0] sp_q;         // Return stack pointer
  pcsc_ctx_s ctx_q;              // Context copies, no reset on purpose
  pcsc_ctx_s restore_q;          // Context handed back on return
  logic restore_valid_q;         // One-cycle restore strobe
  logic [31:0] prdata_q;         // Registered read data
  logic pready_q;                // Registered ready
  logic pslverr_q;               // Registered error
  logic [14:0] stack_mem [STK_DEPTH];  // Return stack storage

  // Decoded access
  pcsc_sel_s sel;
  logic acc_hit;     // Address lands on a mapped register
  logic wr_en;       // Write takes effect this edge
  logic [SP_W-2:0] tos_idx;  // Stack entry under the pointer

  // Decode is combinational from the bus; only the answer is registered
  assign sel = decode(paddr);
  assign acc_hit = sel.hit && mapped(sel.idx);
  // Writes land only at the completing edge, and only when mapped
  assign wr_en = psel && penable && pwrite && pready_q && acc_hit;
  // The spare pointer bit flags over/underflow, so it never indexes
  assign tos_idx = sp_q[SP_W-2:0];

  // Per-register write strobes
  function automatic logic wr_to(input logic en, input logic [11:0] idx,
                                 input logic [11:0] target);
    return en && (idx == target);
  endfunction

  logic pcl_wr;
  logic latch_wr;
  logic sp_wr;
  logic stack_top_low_byte_wr;
  logic stack_top_high_byte_wr;
  assign pcl_wr = wr_to(wr_en, sel.idx, `PCSC_IDX_PC_LOW);
  assign latch_wr = wr_to(wr_en, sel.idx, `PCSC_IDX_PC_LATCH);
  assign sp_wr = wr_to(wr_en, sel.idx, `PCSC_IDX_STK_PTR);
  assign stack_top_low_byte_wr = wr_to(wr_en, sel.idx, `PCSC_IDX_TOS_LOW);
  assign stack_top_high_byte_wr = wr_to(wr_en, sel.idx, `PCSC_IDX_TOS_HIGH);

  // Program counter
  // Resets beat a same-cycle low-byte write, which beats a fetch step.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= `PCSC_PC_RESET;
    end else if (core_reset) begin
      pc_q <= `PCSC_PC_RESET;
    end else if (pcl_wr) begin
      // All fifteen bits change together
      pc_q <= {pc_high_latch_q, pwdata[7:0]};
    end else if (pc_step) begin
      // Fetch advance wraps inside fifteen bits
      pc_q <= 15'(pc_q + 15'h0001);
    end
  end

  // High-part latch, source of the upper counter bits on a low-byte write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_high_latch_q <= `PCSC_LATCH_RESET;
    end else if (core_reset) begin
      pc_high_latch_q <= `PCSC_LATCH_RESET;
    end else if (latch_wr) begin
      pc_high_latch_q <= pwdata[6:0];
    end
  end

  // Return stack pointer
  // Reset value is the empty state, one below entry zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_q <= `PCSC_SP_RESET;
    end else if (core_reset) begin
      sp_q <= `PCSC_SP_RESET;
    end else if (sp_wr) begin
      sp_q <= pwdata[SP_W-1:0];
    end
  end

  // Stack storage, reached through the top-of-stack pair
  // No reset: contents are undefined until software fills them.
  // Only the low pointer bits select, so the empty state shows entry 15.
  always_ff @(posedge clk) begin
    if (stack_top_low_byte_wr) begin
      stack_mem[tos_idx][7:0] <= pwdata[7:0];
    end
    if (stack_top_high_byte_wr) begin
      stack_mem[tos_idx][14:8] <= pwdata[6:0];
    end
  end

  // Context copies
  // Deliberately outside any reset so that no reset disturbs them.
  // Hardware capture wins over a software write in the same cycle.
  always_ff @(posedge clk) begin
    if (irq_entry) begin
      ctx_q <= live_ctx;
    end else if (wr_en) begin
      case (sel.idx)
        `PCSC_IDX_FLAGS_CTX: ctx_q.flags <= pwdata[2:0];
        `PCSC_IDX_WORK_CTX: ctx_q.work <= pwdata[7:0];
        `PCSC_IDX_BANK_CTX: ctx_q.bank <= pwdata[4:0];
        `PCSC_IDX_LATCH_CTX: ctx_q.pc_high_latch <= pwdata[6:0];
        `PCSC_IDX_P0L_CTX: ctx_q.p0l <= pwdata[7:0];
        `PCSC_IDX_P0H_CTX: ctx_q.p0h <= pwdata[7:0];
        `PCSC_IDX_P1L_CTX: ctx_q.p1l <= pwdata[7:0];
        `PCSC_IDX_P1H_CTX: ctx_q.p1h <= pwdata[7:0];
        default: ctx_q <= ctx_q;
      endcase
    end
  end

  // Restore path towards the core on interrupt return
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      restore_valid_q <= 1'b0;
    end else begin
      restore_valid_q <= irq_return;
    end
  end

  // Restore data is a plain copy; only the strobe says it is meaningful
  // Clearing it on power-on keeps the output free of unknowns
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      restore_q <= '0;
    end else if (irq_return) begin
      restore_q <= ctx_q;
    end
  end

  // Read multiplexer; unused upper bits read as zero
  // Stack entries read unknown until written; software fills them first
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (sel.idx)
      `PCSC_IDX_PC_LOW: rd_mux[7:0] = pc_q[7:0];
      `PCSC_IDX_PC_LATCH: rd_mux[6:0] = pc_high_latch_q;
      `PCSC_IDX_FLAGS_CTX: rd_mux[2:0] = ctx_q.flags;
      `PCSC_IDX_WORK_CTX: rd_mux[7:0] = ctx_q.work;
      `PCSC_IDX_BANK_CTX: rd_mux[4:0] = ctx_q.bank;
      `PCSC_IDX_LATCH_CTX: rd_mux[6:0] = ctx_q.pc_high_latch;
      `PCSC_IDX_P0L_CTX: rd_mux[7:0] = ctx_q.p0l;
      `PCSC_IDX_P0H_CTX: rd_mux[7:0] = ctx_q.p0h;
      `PCSC_IDX_P1L_CTX: rd_mux[7:0] = ctx_q.p1l;
      `PCSC_IDX_P1H_CTX: rd_mux[7:0] = ctx_q.p1h;
      `PCSC_IDX_STK_PTR: rd_mux[SP_W-1:0] = sp_q;
      `PCSC_IDX_TOS_LOW: rd_mux[7:0] = stack_mem[tos_idx][7:0];
      `PCSC_IDX_TOS_HIGH: rd_mux[6:0] = stack_mem[tos_idx][14:8];
      default: rd_mux = '0;
    endcase
    // Misses and misaligned addresses read as zero
    if (!acc_hit) begin
      rd_mux = '0;
    end
  end

  // APB answer: one wait state so that all outputs come from flops
  // Fixed latency costs a cycle per access but keeps the master simple.
  // A master that drops psel early simply abandons the answer.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !acc_hit;
    end
  end

  // Read data captured in the first access cycle, held for the ready cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= '0;
    end else if (psel && penable && !pready_q) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pc = pc_q;
  assign restore_ctx = restore_q;
  assign restore_valid = restore_valid_q;

  // Checks on the block's own behaviour
  // All of them are idle while the power-on reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Low-byte write: counter takes latch and written byte
  pcl_load_a: assert property (
    pcl_wr && !core_reset |=> pc_q == {$past(pc_high_latch_q), $past(pwdata[7:0])})
    else $error("pc not loaded from latch and low byte");

  // Fetch step wraps modulo fifteen bits
  pc_step_a: assert property (
    pc_step && !pcl_wr && !core_reset |=> pc_q == 15'($past(pc_q) + 15'h0001))
    else $error("pc step wrong");

  // Upper bits move only through write, step or reset
  pc_upper_a: assert property (
    !pcl_wr && !pc_step && !core_reset |=> $stable(pc_q[14:8]))
    else $error("pc upper bits changed without cause");

  // Core reset clears the counter and empties the stack
  pc_reset_a: assert property (
    core_reset |=> pc_q == `PCSC_PC_RESET && sp_q == `PCSC_SP_RESET)
    else $error("reset did not clear pc and pointer");

  // Read of the low byte returns the counter
  pcl_read_a: assert property (
    psel && penable && !pready_q && !pwrite && acc_hit
      && sel.idx == `PCSC_IDX_PC_LOW
      |=> pready_q && prdata_q == {24'h000000, $past(pc_q[7:0])})
    else $error("low byte read mismatch");

  // Latch copy untouched by core reset
  latch_keep_a: assert property (
    core_reset && !irq_entry && !wr_en |=> ctx_q.pc_high_latch == $past(ctx_q.pc_high_latch))
    else $error("latch copy disturbed by reset");

  // Pointer 1 high copy untouched by core reset
  p1h_keep_a: assert property (
    core_reset && !irq_entry && !wr_en |=> ctx_q.p1h == $past(ctx_q.p1h))
    else $error("pointer1 high copy disturbed by reset");

  // Bank copy untouched by core reset
  bank_keep_a: assert property (
    core_reset && !irq_entry && !wr_en |=> ctx_q.bank == $past(ctx_q.bank))
    else $error("bank copy disturbed by reset");

  // Pointer read shows five bits only
  sp_read_a: assert property (
    psel && penable && !pready_q && !pwrite && acc_hit
      && sel.idx == `PCSC_IDX_STK_PTR |=> prdata_q[31:SP_W] == '0)
    else $error("stack pointer read wider than five bits");

  // Entry captures, return hands back the same set
  ctx_round_a: assert property (
    irq_entry ##1 (irq_return && !irq_entry && !wr_en)
      |=> restore_valid_q && restore_q == $past(live_ctx, 2))
    else $error("context not restored as captured");

  // Latch write takes the low seven data bits
  latch_write_a: assert property (
    latch_wr && !core_reset |=> pc_high_latch_q == $past(pwdata[6:0]))
    else $error("latch write not taken");

  // Pointer write keeps only its five bits
  sp_write_a: assert property (
    sp_wr && !core_reset |=> sp_q == $past(pwdata[SP_W-1:0]))
    else $error("stack pointer write not taken");

  // Entry copies the whole live context
  ctx_capture_a: assert property (
    irq_entry |=> ctx_q == $past(live_ctx))
    else $error("context not captured on entry");

  // Return raises the strobe with the stored copies
  restore_take_a: assert property (
    irq_return |=> restore_valid_q && restore_q == $past(ctx_q))
    else $error("restore strobe or data wrong");

endmodule // pcsc_regs

// [tb/pc_stack_context_regs_tb.sv]
// Self-checking bench for the program counter, stack window and context copies.
// Assumes pcsc_regs answers APB with one wait state and core strobes act one edge later.
`timescale 1ns/1ps
`include "pcsc_defs.svh"

module pc_stack_context_regs_tb;
  import pcsc_pkg::*;
  // Clock, resets and APB master signals
  logic clk = 1'b0;
  logic rstn, core_reset, psel, penable, pwrite, pready, pslverr;
  logic [`PCSC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  logic [1:0] mis = 2'b00;  // Low address bits, nonzero only to test refusal
  // Core strobes and context
  logic pc_step, irq_entry, irq_return, restore_valid;
  logic [14:0] pc;
  pcsc_ctx_s live_ctx, restore_ctx, ctx_v;
  // Copy widths differ per register, so expectations are masked
  logic [7:0] msk [8] = '{8'h07, 8'hff, 8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
  int n_errors = 0;
  int checks = 0;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  pcsc_regs pcsc_regs_i (.clk(clk), .rstn(rstn), .core_reset(core_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc_step(pc_step), .irq_entry(irq_entry),
    .irq_return(irq_return), .live_ctx(live_ctx), .pc(pc), .restore_ctx(restore_ctx),
    .restore_valid(restore_valid));

  // One comparison, counted; case inequality so unknowns fail
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; waits on pready under a bound rather than a fixed count
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, mis};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("pready", 64'h1, 64'h0);
    end
    #1;
  endtask

  // Read a register and compare data and error flag
  task automatic rchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(name, 64'(exp), 64'(rd));
    chk(name, 64'h0, 64'(err));
  endtask

  // One-cycle strobe on a core input, result settled afterwards
  task automatic pulse(input logic rst);
    @(posedge clk);
    if (rst) begin
      core_reset <= 1'b1;
    end else begin
      pc_step <= 1'b1;
    end
    @(posedge clk);
    core_reset <= 1'b0;
    pc_step <= 1'b0;
    #1;
  endtask

  // Verdict and end of run, shared with the watchdog
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim;
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    core_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pc_step = 1'b0;
    irq_entry = 1'b0;
    irq_return = 1'b0;
    live_ctx = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("pc after reset", 64'h0, 64'(pc));
    rchk("stack pointer", `PCSC_IDX_STK_PTR, 32'h1f);
    // Low byte write pulls the upper bits from the latch
    apb(1'b1, `PCSC_IDX_PC_LATCH, 32'hffffff55);
    chk("pc before low write", 64'h0, 64'(pc));
    apb(1'b1, `PCSC_IDX_PC_LOW, 32'h123456a3);
    chk("pc load", 64'h55a3, 64'(pc));
    rchk("pc low", `PCSC_IDX_PC_LOW, 32'ha3);
    pulse(1'b0);
    chk("pc step", 64'h55a4, 64'(pc));
    // Top of the 15-bit range, then wrap
    apb(1'b1, `PCSC_IDX_PC_LATCH, 32'hff);
    rchk("latch", `PCSC_IDX_PC_LATCH, 32'h7f);
    apb(1'b1, `PCSC_IDX_PC_LOW, 32'hff);
    chk("pc top", 64'h7fff, 64'(pc));
    pulse(1'b0);
    chk("pc wrap", 64'h0, 64'(pc));
    // Context copies, upper data bits set to prove they read back 0
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'(`PCSC_IDX_FLAGS_CTX + i), {24'hffffff, 8'h96 ^ 8'(i * 37)});
    end
    apb(1'b1, `PCSC_IDX_PC_LOW, 32'h3c);
    pulse(1'b1);
    chk("pc core reset", 64'h0, 64'(pc));
    rchk("latch core reset", `PCSC_IDX_PC_LATCH, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rchk("ctx copy", 12'(`PCSC_IDX_FLAGS_CTX + i), 32'((8'h96 ^ 8'(i * 37)) & msk[i]));
    end
    // Stack pointer width and top-of-stack pair
    apb(1'b1, `PCSC_IDX_STK_PTR, 32'hff);
    rchk("stack pointer width", `PCSC_IDX_STK_PTR, 32'h1f);
    apb(1'b1, `PCSC_IDX_STK_PTR, 32'h3);
    apb(1'b1, `PCSC_IDX_TOS_LOW, 32'ha5);
    apb(1'b1, `PCSC_IDX_TOS_HIGH, 32'hff);
    rchk("tos low", `PCSC_IDX_TOS_LOW, 32'ha5);
    rchk("tos high", `PCSC_IDX_TOS_HIGH, 32'h7f);
    // Unmapped slot inside the block's range is refused
    apb(1'b1, 12'hfec, 32'hff);
    chk("unmapped write err", 64'h1, 64'(err));
    apb(1'b0, 12'hfec, 32'h0);
    chk("unmapped read", 64'h1, {32'(rd), 31'h0, err});
    // Misaligned byte address is refused and the write dropped
    mis = 2'b10;
    apb(1'b1, `PCSC_IDX_PC_LATCH, 32'h11);
    mis = 2'b00;
    chk("misaligned write err", 64'h1, 64'(err));
    rchk("latch after misaligned", `PCSC_IDX_PC_LATCH, 32'h0);
    // Interrupt entry captures, return hands the copies back
    ctx_v = '{flags: 3'h5, work: 8'hc3, bank: 5'h16, pc_high_latch: 7'h2b,
      p0l: 8'h11, p0h: 8'h22, p1l: 8'h33, p1h: 8'h44};
    @(posedge clk);
    irq_entry <= 1'b1;
    live_ctx <= ctx_v;
    @(posedge clk);
    irq_entry <= 1'b0;
    irq_return <= 1'b1;
    live_ctx <= ~ctx_v;
    @(posedge clk);
    irq_return <= 1'b0;
    #1;
    chk("restore valid", 64'h1, 64'(restore_valid));
    chk("restore ctx", 64'(ctx_v), 64'(restore_ctx));
    @(posedge clk);
    #1;
    chk("restore valid drop", 64'h0, 64'(restore_valid));
    rchk("latch copy", `PCSC_IDX_LATCH_CTX, 32'h2b);
    rchk("ptr1 high copy", `PCSC_IDX_P1H_CTX, 32'h44);
    rchk("bank copy", `PCSC_IDX_BANK_CTX, 32'h16);
    rchk("flags copy", `PCSC_IDX_FLAGS_CTX, 32'h5);
    // Power-on reset in mid-run clears the counter again
    apb(1'b1, `PCSC_IDX_PC_LOW, 32'h5a);
    chk("pc before second reset", 64'h5a, 64'(pc));
    @(posedge clk);
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("pc after second reset", 64'h0, 64'(pc));
    rchk("pointer after second reset", `PCSC_IDX_STK_PTR, 32'h1f);
    end_sim;
  end
endmodule // pc_stack_context_regs_tb
